// ==== col_limiter.sv ====
// Function
// - Range minimum 1 kA in auto modes, 2 kA otherwise; ceiling 99.99 kA.
// - Preset primary modes cap range at turns ratio times sensor factor, max 99.99.
// - Amplifier gain follows the stored range automatically.
// - Operate mode with offset lets only weld current change among schedule values.
// - Offset code 00 disables; 01 to 19 give single-schedule window of that percent.
// - Code 20 disables; 21 to 39 give all-schedule window of code minus 20.
// - All-schedule change applies to every schedule 00 to 49.
// - Display first digit shows single or all indicator per code.
// - Operate current moves only between base minus and base plus offset.
// - Values past a window edge are stored and shown as that edge.
// - kA mode commits on enter, even in non-CC mode; percent mode commits on each press.
// - All-schedule mode shifts every schedule by the same amount, saturating at 0 and 99.99.
// - Single-schedule mode writes only the displayed schedule.
// - Program mode with offset alternates base and offset current display.
// - Upper and lower current limits reachable only in constant-current mode.
// - Enter while offset current shown copies it into the base current.
// - kA window is a percentage of maximum RMS current.
`timescale 1ns/100ps
module col_limiter
	import col_pkg::*;
#(
	parameter int BLINK_CYC = COL_BLINK_CYC
)(
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	input wire logic [5:0] I_CC_MODE,
	input wire logic [7:0] I_TURNS_RATIO,
	input wire logic I_RANGE_WR,
	input wire logic [13:0] I_RANGE_DATA,
	input wire logic I_OFFSET_WR,
	input wire logic [5:0] I_OFFSET_CODE,
	input wire logic I_OPERATE,
	input wire logic I_KA_MODE,
	input wire logic [13:0] I_MAX_RMS,
	input wire logic [5:0] I_SCHED_SEL,
	input wire logic I_PRG_WR,
	input wire logic [13:0] I_PRG_DATA,
	input wire logic I_DATA_UP,
	input wire logic I_DATA_DN,
	input wire logic I_ENTER,
	output logic [13:0] O_RANGE,
	output logic [1:0] O_AMP_GAIN,
	output logic [5:0] O_OFFSET_CODE,
	output logic [1:0] O_OFS_MODE,
	output logic [4:0] O_OFS_PCT,
	output logic [1:0] O_IND_DIGIT,
	output logic [13:0] O_CUR_VAL,
	output logic [13:0] O_DISP_VAL,
	output logic O_DISP_OFFSET,
	output logic O_PARAM_LOCK,
	output logic O_LIMITS_EN,
	output logic O_REJECT
);
	typedef struct packed {
		logic [13:0] range;
		logic [5:0] ocode;
		logic [COL_SCHED_NUM-1:0][13:0] base;
		logic [COL_SCHED_NUM-1:0][13:0] op;
		logic [13:0] pend;
		logic pend_vld;
		logic [25:0] cnt;
		logic show_ofs;
		logic reject;
	} col_state_type;

	col_state_type st_r, st_nxt;
	col_ofs_type ofs_mode;
	logic cc_on, auto_cmp, auto_rng, range_ok, ocode_ok, sel_ok, commit;
	logic [13:0] rmin, rmax, cur_base, cur_op, lo, hi, src, req, cval;
	logic [15:0] prod;
	logic [7:0] fact;
	logic [4:0] pct;
	logic signed [15:0] delta, sum;

	assign sel_ok = I_SCHED_SEL <= COL_SCHED_LAST;
	assign cur_base = sel_ok ? st_r.base[I_SCHED_SEL] : 14'h0000;
	assign cur_op = sel_ok ? st_r.op[I_SCHED_SEL] : 14'h0000;

	always_comb begin
		cc_on = 1'b1;
		auto_rng = 1'b0;
		fact = 8'h00;
		case (I_CC_MODE)
			COL_CR_AP_CMP, COL_CR_AP_MON, COL_CR_AS_CMP, COL_CR_AS_MON: auto_rng = 1'b1;
			COL_CR_P200_C, COL_CR_P200_M: fact = COL_FACT_200A;
			COL_CR_P500_C, COL_CR_P500_M: fact = COL_FACT_500A;
			COL_CR_P1K_C, COL_CR_P1K_M: fact = COL_FACT_1KA;
			COL_CR_P2K_C, COL_CR_P2K_M: fact = COL_FACT_2KA;
			COL_CR_S_CMP, COL_CR_S_MON: ;
			default: cc_on = 1'b0;
		endcase
	end
	assign auto_cmp = (I_CC_MODE == COL_CR_AP_CMP) || (I_CC_MODE == COL_CR_AS_CMP);
	assign prod = 16'(I_TURNS_RATIO) * 16'(fact);
	assign rmin = auto_rng ? COL_MIN_AUTO : COL_MIN_PRESET;
	assign rmax = (fact == 8'h00 || prod > 16'(COL_FULL_SCALE)) ? COL_FULL_SCALE
		: prod[13:0];
	assign range_ok = cc_on && ((I_RANGE_DATA >= rmin && I_RANGE_DATA <= rmax)
		|| (auto_cmp && I_RANGE_DATA == COL_RANGE_PCT));
	assign ocode_ok = I_OFFSET_CODE <= COL_OCODE_LAST;

	always_comb begin
		ofs_mode = COL_OFS_OFF;
		pct = 5'h00;
		if (st_r.ocode > COL_OCODE_ALL_OFF) begin
			ofs_mode = COL_OFS_ALL;
			pct = 5'(st_r.ocode - COL_OCODE_ALL_OFF);
		end else if (st_r.ocode != COL_OCODE_RST && st_r.ocode != COL_OCODE_ALL_OFF) begin
			ofs_mode = COL_OFS_SINGLE;
			pct = st_r.ocode[4:0];
		end
	end

	col_window u_window (
		.i_base(cur_base),
		.i_pct(pct),
		.i_ka(I_KA_MODE),
		.i_max_rms(I_MAX_RMS),
		.o_lo(lo),
		.o_hi(hi)
	);

	always_comb begin
		src = st_r.pend_vld ? st_r.pend : cur_op;
		req = src;
		if (I_DATA_UP)
			req = (src < COL_FULL_SCALE) ? src + 14'h0001 : src;
		else if (I_DATA_DN)
			req = (src > 14'h0000) ? src - 14'h0001 : src;
		if (req > hi)
			req = hi;
		else if (req < lo)
			req = lo;
	end

	always_comb begin
		st_nxt = st_r;
		commit = 1'b0;
		cval = req;
		delta = 16'sh0000;
		sum = 16'sh0000;
		st_nxt.reject = 1'b0;
		if (st_r.cnt == 26'(BLINK_CYC - 1)) begin
			st_nxt.cnt = 26'h0000000;
			st_nxt.show_ofs = !st_r.show_ofs;
		end else begin
			st_nxt.cnt = st_r.cnt + 26'h0000001;
		end
		if (I_RANGE_WR) begin
			if (range_ok)
				st_nxt.range = I_RANGE_DATA;
			else
				st_nxt.reject = 1'b1;
		end
		if (I_OFFSET_WR) begin
			if (ocode_ok)
				st_nxt.ocode = I_OFFSET_CODE;
			else
				st_nxt.reject = 1'b1;
		end
		if (!I_OPERATE) begin
			st_nxt.pend_vld = 1'b0;
			if (sel_ok && I_PRG_WR) begin
				st_nxt.base[I_SCHED_SEL] = I_PRG_DATA;
				st_nxt.op[I_SCHED_SEL] = I_PRG_DATA;
			end else if (sel_ok && I_ENTER && ofs_mode != COL_OFS_OFF && st_r.show_ofs) begin
				st_nxt.base[I_SCHED_SEL] = cur_op;
			end
		end else if (sel_ok && ofs_mode != COL_OFS_OFF) begin
			if (I_KA_MODE) begin
				if (I_DATA_UP || I_DATA_DN) begin
					st_nxt.pend = req;
					st_nxt.pend_vld = 1'b1;
				end else if (I_ENTER) begin
					commit = 1'b1;
				end
			end else begin
				commit = I_DATA_UP || I_DATA_DN;
			end
		end
		if (commit) begin
			st_nxt.pend_vld = 1'b0;
			if (ofs_mode == COL_OFS_ALL) begin
				delta = $signed(16'(cval)) - $signed(16'(cur_base));
				for (int i = 0; i < COL_SCHED_NUM; i++) begin
					sum = $signed(16'(st_r.base[i])) + delta;
					if (sum < 16'sh0000)
						st_nxt.op[i] = 14'h0000;
					else if (sum > $signed(16'(COL_FULL_SCALE)))
						st_nxt.op[i] = COL_FULL_SCALE;
					else
						st_nxt.op[i] = sum[13:0];
				end
			end else begin
				st_nxt.op[I_SCHED_SEL] = cval;
			end
		end
	end

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			st_r <= '0;
			st_r.range <= COL_RANGE_RST;
			st_r.ocode <= COL_OCODE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Full-scale gain for the percent-of-capability setting
	always_comb begin
		if (st_r.range == COL_RANGE_PCT || st_r.range > COL_GAIN_T2)
			O_AMP_GAIN = 2'h3;
		else if (st_r.range > COL_GAIN_T1)
			O_AMP_GAIN = 2'h2;
		else if (st_r.range > COL_GAIN_T0)
			O_AMP_GAIN = 2'h1;
		else
			O_AMP_GAIN = 2'h0;
	end

	assign O_RANGE = st_r.range;
	assign O_OFFSET_CODE = st_r.ocode;
	assign O_OFS_MODE = ofs_mode;
	assign O_OFS_PCT = pct;
	assign O_IND_DIGIT = ofs_mode;
	assign O_CUR_VAL = cur_op;
	assign O_DISP_OFFSET = !I_OPERATE && ofs_mode != COL_OFS_OFF && st_r.show_ofs;
	assign O_DISP_VAL = I_OPERATE ? (st_r.pend_vld ? st_r.pend : cur_op)
		: (O_DISP_OFFSET ? cur_op : cur_base);
	assign O_PARAM_LOCK = I_OPERATE;
	assign O_LIMITS_EN = cc_on;
	assign O_REJECT = st_r.reject;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);

	range_hold_a: assert property (!I_RANGE_WR |=> $stable(O_RANGE))
		else $error("range changed without a write");
	range_min_a: assert property (I_RANGE_WR && I_RANGE_DATA < rmin
		&& !(auto_cmp && I_RANGE_DATA == COL_RANGE_PCT) |=> $stable(O_RANGE) && O_REJECT)
		else $error("range below minimum accepted");
	range_max_a: assert property (I_RANGE_WR && I_RANGE_DATA > rmax
		|=> $stable(O_RANGE) && O_REJECT)
		else $error("range above maximum accepted");
	range_pct_a: assert property (I_RANGE_WR && auto_cmp
		&& I_RANGE_DATA == COL_RANGE_PCT |=> O_RANGE == COL_RANGE_PCT)
		else $error("0.99 range refused in auto compensation");
	amp_gain_a: assert property (O_RANGE == COL_RANGE_PCT |-> O_AMP_GAIN == 2'h3)
		else $error("gain not full scale for 0.99 range");
	single_dec_a: assert property (O_OFS_MODE == COL_OFS_SINGLE
		|-> O_OFS_PCT == O_OFFSET_CODE[4:0] && O_OFFSET_CODE < COL_OCODE_ALL_OFF)
		else $error("single window decode wrong");
	all_dec_a: assert property (O_OFS_MODE == COL_OFS_ALL
		|-> 6'(O_OFS_PCT) + COL_OCODE_ALL_OFF == O_OFFSET_CODE)
		else $error("all window decode wrong");
	window_clamp_a: assert property (commit ##1 $stable(I_SCHED_SEL)
		|-> O_CUR_VAL <= $past(hi) && O_CUR_VAL >= $past(lo))
		else $error("committed current outside window");
	ka_enter_a: assert property (commit && I_KA_MODE |-> I_ENTER)
		else $error("kA commit without enter");
	op_lock_a: assert property (I_OPERATE && O_OFS_MODE == COL_OFS_OFF && !I_PRG_WR
		##1 $stable(I_SCHED_SEL) |-> $stable(O_CUR_VAL))
		else $error("current changed with offset disabled");
	base_copy_a: assert property (O_DISP_OFFSET && I_ENTER && !I_PRG_WR && sel_ok
		##1 $stable(I_SCHED_SEL) |-> cur_base == $past(cur_op))
		else $error("offset current not copied to base");

	all_commit_c: cover property (commit && ofs_mode == COL_OFS_ALL);
	ka_enter_c: cover property (I_OPERATE && I_KA_MODE && I_ENTER && st_r.pend_vld);
	reject_c: cover property (O_REJECT);
endmodule

// ==== col_oper.sv ====
`timescale 1ns/100ps
module col_oper (
	input wire logic i_clk,
	output logic o_up,
	output logic o_dn,
	output logic o_enter
);
	initial begin
		o_up = 1'b0;
		o_dn = 1'b0;
		o_enter = 1'b0;
	end
	// One press: high one cycle, then a quiet cycle so presses never merge
	task automatic press(input int k);
		@(negedge i_clk);
		o_up = (k == 0);
		o_dn = (k == 1);
		o_enter = (k > 1);
		@(negedge i_clk);
		o_up = 1'b0;
		o_dn = 1'b0;
		o_enter = 1'b0;
		@(negedge i_clk);
	endtask
endmodule

// ==== col_pkg.sv ====
package col_pkg;
	// Current values are hundredths of kA (kA mode) or whole percent (% mode)
	localparam logic [13:0] COL_FULL_SCALE = 14'h270F; // 99.99 kA
	localparam logic [13:0] COL_MIN_AUTO = 14'h0064; // 1.00 kA
	localparam logic [13:0] COL_MIN_PRESET = 14'h00C8; // 2.00 kA
	localparam logic [13:0] COL_RANGE_PCT = 14'h0063; // 0.99: percent of capability
	localparam logic [7:0] COL_FACT_200A = 8'h14; // 0.2 kA per turn
	localparam logic [7:0] COL_FACT_500A = 8'h32;
	localparam logic [7:0] COL_FACT_1KA = 8'h64;
	localparam logic [7:0] COL_FACT_2KA = 8'hC8;
	localparam logic [13:0] COL_RANGE_RST = 14'h270F;
	localparam logic [5:0] COL_OCODE_RST = 6'h00;
	localparam logic [5:0] COL_OCODE_ALL_OFF = 6'h14; // 20
	localparam logic [5:0] COL_OCODE_LAST = 6'h27; // 39
	localparam logic [5:0] COL_SCHED_LAST = 6'h31; // 49
	localparam int COL_SCHED_NUM = 50;
	// Amplifier gain steps chosen by range
	localparam logic [13:0] COL_GAIN_T0 = 14'h01F4; // 5 kA
	localparam logic [13:0] COL_GAIN_T1 = 14'h07D0; // 20 kA
	localparam logic [13:0] COL_GAIN_T2 = 14'h1388; // 50 kA
	localparam int COL_MCLK_KHZ = 200000;
	localparam int COL_BLINK_MS = 250;
	localparam int COL_BLINK_CYC = COL_BLINK_MS * COL_MCLK_KHZ;
	typedef enum logic [1:0] {COL_OFS_OFF, COL_OFS_SINGLE, COL_OFS_ALL} col_ofs_type;
	// Constant-current mode codes
	localparam logic [5:0] COL_CR_AP_CMP = 6'h0A; // 10
	localparam logic [5:0] COL_CR_AP_MON = 6'h0B;
	localparam logic [5:0] COL_CR_P200_C = 6'h0C;
	localparam logic [5:0] COL_CR_P200_M = 6'h0D;
	localparam logic [5:0] COL_CR_P500_C = 6'h0E;
	localparam logic [5:0] COL_CR_P500_M = 6'h0F;
	localparam logic [5:0] COL_CR_P1K_C = 6'h10;
	localparam logic [5:0] COL_CR_P1K_M = 6'h11;
	localparam logic [5:0] COL_CR_P2K_C = 6'h12;
	localparam logic [5:0] COL_CR_P2K_M = 6'h13;
	localparam logic [5:0] COL_CR_AS_CMP = 6'h1E; // 30
	localparam logic [5:0] COL_CR_AS_MON = 6'h1F;
	localparam logic [5:0] COL_CR_S_CMP = 6'h20;
	localparam logic [5:0] COL_CR_S_MON = 6'h21;
endpackage

// ==== col_window.sv ====
`timescale 1ns/100ps
module col_window
	import col_pkg::*;
(
	input wire logic [13:0] i_base,
	input wire logic [4:0] i_pct,
	input wire logic i_ka,
	input wire logic [13:0] i_max_rms,
	output logic [13:0] o_lo,
	output logic [13:0] o_hi
);
	logic [18:0] prod;
	logic [13:0] amt;
	logic [14:0] sum;
	assign prod = 19'(i_pct) * 19'(i_max_rms);
	// kA window is a share of max RMS, not of the base value
	assign amt = i_ka ? 14'(prod / 19'd100) : 14'(i_pct);
	assign sum = 15'(i_base) + 15'(amt);
	assign o_hi = (sum > 15'(COL_FULL_SCALE)) ? COL_FULL_SCALE : sum[13:0];
	assign o_lo = (i_base > amt) ? i_base - amt : 14'h0000;
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
	import col_pkg::*;
	logic mclk, rst_b, rwr, owr, opr, ka, pwr, up, dn, ent;
	logic [5:0] cc, ocode, sel, ocd;
	logic [7:0] tr;
	logic [13:0] rdat, rms, pdat, rng, cur, disp;
	logic [1:0] gain, omode, ind;
	logic [4:0] opct;
	logic dofs, lock, lim, rej, s0, s1;
	int mismatches, checked, cyc, n;
	localparam logic [5:0] CD [6] = '{6'h00, 6'h05, 6'h13, 6'h14, 6'h15, 6'h27};
	localparam logic [1:0] MD [6] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h2};
	localparam logic [4:0] PC [6] = '{5'h00, 5'h05, 5'h13, 5'h00, 5'h01, 5'h13};
	col_limiter #(.BLINK_CYC(4)) dut (.I_MCLK(mclk), .I_RST_B(rst_b), .I_CC_MODE(cc),
		.I_TURNS_RATIO(tr), .I_RANGE_WR(rwr), .I_RANGE_DATA(rdat), .I_OFFSET_WR(owr),
		.I_OFFSET_CODE(ocode), .I_OPERATE(opr), .I_KA_MODE(ka), .I_MAX_RMS(rms),
		.I_SCHED_SEL(sel), .I_PRG_WR(pwr), .I_PRG_DATA(pdat), .I_DATA_UP(up), .I_DATA_DN(dn),
		.I_ENTER(ent), .O_RANGE(rng), .O_AMP_GAIN(gain), .O_OFFSET_CODE(ocd),
		.O_OFS_MODE(omode), .O_OFS_PCT(opct), .O_IND_DIGIT(ind), .O_CUR_VAL(cur),
		.O_DISP_VAL(disp), .O_DISP_OFFSET(dofs), .O_PARAM_LOCK(lock), .O_LIMITS_EN(lim),
		.O_REJECT(rej));
	col_oper op (.i_clk(mclk), .o_up(up), .o_dn(dn), .o_enter(ent));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(input logic [13:0] s, input logic [13:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr_rng(input logic [13:0] d);
		@(negedge mclk);
		rwr = 1'b1;
		rdat = d;
		@(negedge mclk);
		rwr = 1'b0;
	endtask
	task automatic wr_ofs(input logic [5:0] c);
		@(negedge mclk);
		owr = 1'b1;
		ocode = c;
		@(negedge mclk);
		owr = 1'b0;
	endtask
	task automatic prg(input logic [5:0] s, input logic [13:0] d);
		@(negedge mclk);
		sel = s;
		pwr = 1'b1;
		pdat = d;
		@(negedge mclk);
		pwr = 1'b0;
		@(negedge mclk);
	endtask
	task automatic set_mode(input logic [5:0] m, input logic [7:0] r);
		cc = m;
		tr = r;
	endtask
	task automatic set_op(input logic o, input logic k, input logic [13:0] r);
		opr = o;
		ka = k;
		rms = r;
	endtask
	task automatic t_range();
		chk(rng, COL_RANGE_RST);
		chk(ocd, 14'h0000);
		set_mode(COL_CR_AP_CMP, 8'h00);
		wr_rng(14'h0063);
		chk(rng, 14'h0063);
		chk(gain, 14'h0003);
		wr_rng(14'h0064);
		chk(rng, 14'h0064);
		chk(gain, 14'h0000);
		set_mode(COL_CR_S_CMP, 8'h00);
		wr_rng(14'h0063);
		chk(rej, 14'h0001);
		chk(rng, 14'h0064);
		set_mode(COL_CR_P200_C, 8'h64);
		wr_rng(14'h07D1);
		chk(rej, 14'h0001);
		wr_rng(14'h07D0);
		chk(rng, 14'h07D0);
		chk(gain, 14'h0001);
		set_mode(COL_CR_P2K_M, 8'hFF);
		wr_rng(14'h270F);
		chk(rng, 14'h270F);
		chk(gain, 14'h0003);
		set_mode(COL_CR_P500_M, 8'h0A);
		wr_rng(14'h01F5);
		chk(rej, 14'h0001);
		wr_rng(14'h01F4);
		chk(rng, 14'h01F4);
		set_mode(COL_CR_P1K_C, 8'h0A);
		wr_rng(14'h03E9);
		chk(rej, 14'h0001);
		wr_rng(14'h03E8);
		chk(rng, 14'h03E8);
		set_mode(COL_CR_AS_MON, 8'h00);
		wr_rng(14'h0063);
		chk(rej, 14'h0001);
		set_mode(COL_CR_AS_CMP, 8'h00);
		wr_rng(14'h0063);
		chk(rng, 14'h0063);
		set_mode(COL_CR_S_MON, 8'h00);
		wr_rng(14'h1388);
		chk(rng, 14'h1388);
		chk(gain, 14'h0002);
		set_mode(6'h00, 8'h00);
		wr_rng(14'h0190);
		chk(rej, 14'h0001);
		chk(rng, 14'h1388);
		chk(lim, 14'h0000);
		set_mode(COL_CR_AP_CMP, 8'h00);
		@(negedge mclk);
		chk(lim, 14'h0001);
		$display("range test done");
	endtask
	task automatic t_code();
		for (int i = 0; i < 6; i++) begin
			wr_ofs(CD[i]);
			chk(omode, MD[i]);
			chk(ind, MD[i]);
			if (MD[i] != 2'h0) chk(opct, PC[i]);
		end
		wr_ofs(6'h28);
		chk(rej, 14'h0001);
		chk(ocd, 14'h0027);
		$display("code test done");
	endtask
	task automatic t_single();
		prg(6'h03, 14'h0046);
		prg(6'h04, 14'h0028);
		wr_ofs(6'h00);
		set_op(1'b1, 1'b0, 14'h0000);
		sel = 6'h03;
		op.press(0);
		chk(cur, 14'h0046);
		set_op(1'b0, 1'b0, 14'h0000);
		wr_ofs(6'h05);
		set_op(1'b1, 1'b0, 14'h0000);
		op.press(0);
		chk(lock, 14'h0001);
		chk(cur, 14'h0047);
		repeat (6) op.press(0);
		chk(cur, 14'h004B);
		repeat (12) op.press(1);
		chk(cur, 14'h0041);
		repeat (10) op.press(0);
		prg(6'h03, 14'h0000);
		chk(cur, 14'h004B);
		sel = 6'h04;
		@(negedge mclk);
		chk(cur, 14'h0028);
		$display("single test done");
	endtask
	task automatic t_blink();
		set_op(1'b0, 1'b0, 14'h0000);
		sel = 6'h03;
		chk(lock, 14'h0000);
		s0 = 1'b0;
		s1 = 1'b0;
		repeat (12) begin
			@(negedge mclk);
			s0 = s0 | (dofs === 1'b0);
			s1 = s1 | (dofs === 1'b1);
		end
		chk(s0 & s1, 14'h0001);
		for (n = 0; n < 12 && dofs !== 1'b0; n++) @(negedge mclk);
		for (n = 0; n < 12 && dofs !== 1'b1; n++) @(negedge mclk);
		op.press(2);
		for (n = 0; n < 12 && dofs !== 1'b0; n++) @(negedge mclk);
		chk(disp, 14'h004B);
		$display("blink test done");
	endtask
	task automatic t_all();
		wr_ofs(6'h16);
		prg(6'h00, 14'h0032);
		prg(6'h01, 14'h003C);
		set_op(1'b1, 1'b0, 14'h0000);
		sel = 6'h00;
		op.press(0);
		chk(cur, 14'h0033);
		sel = 6'h01;
		@(negedge mclk);
		chk(cur, 14'h003D);
		sel = 6'h04;
		@(negedge mclk);
		chk(cur, 14'h0029);
		$display("all test done");
	endtask
	task automatic t_ka();
		set_op(1'b0, 1'b1, 14'h07D0);
		wr_ofs(6'h05);
		prg(6'h05, 14'h0578);
		set_op(1'b1, 1'b1, 14'h07D0);
		op.press(0);
		chk(cur, 14'h0578);
		chk(disp, 14'h0579);
		op.press(2);
		chk(cur, 14'h0579);
		repeat (100) op.press(0);
		op.press(2);
		chk(cur, 14'h05DC);
		$display("ka test done");
	endtask
	task automatic give_verdict();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Hang guard, well above the roughly 500 cycles the tests need
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 8000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		{rwr, owr, opr, ka, pwr} = 5'h00;
		{cc, ocode, sel, tr} = 26'h0000000;
		{rdat, rms, pdat} = 42'h00000000000;
		rst_b = 1'b0;
		repeat (16) @(negedge mclk);
		rst_b = 1'b1;
		t_range();
		t_code();
		t_single();
		t_blink();
		t_all();
		t_ka();
		give_verdict();
	end
endmodule
